// ==== pkg/edma_defines.svh ====
`ifndef EDMA_DEFINES_SVH
`define EDMA_DEFINES_SVH
`define OFS_MODE        12'h000
`define OFS_RX_REQ      12'h004
`define OFS_RX_BASE     12'h008
`define OFS_STATUS      12'h00C
`define OFS_PERMIT      12'h010
`define OFS_TX_IRQ_MODE 12'h014
`define OFS_DESC_PTR    12'h018
`define BIT_SWR         0
`define BIT_RR          0
`define BIT_DL_LO       4
`define BIT_TIS         0
`define BIT_WB          30
`define BIT_TRANSMIT_ABORT_FLAG        26
`define BIT_RECEIVE_ABORT_FLAG        25
`define BIT_FRAME_COUNTER_OVERFLOW_FLAG       24
`define BIT_ADE         23
`define BIT_ECI         22
`define STATUS_MASK     32'h47C00000
`define STATUS_W1C      32'h47800000
`define RX_BASE_RESET   32'h00000000
`define DESC_WB_OFS     32'h00000000
`endif

// ==== pkg/edma_pkg.sv ====
package edma_pkg;
  typedef enum logic [1:0] {DL_16, DL_32, DL_64, DL_RSV} desc_len_e;
  typedef enum {RX_OFF, RX_FETCH, RX_WAIT, RX_READY, RX_WB} rx_state_e;
endpackage

// ==== pkg/edma_link_if.sv ====
`timescale 1ns/1ps
interface edma_link_if;
  logic        fetch_req;
  logic [31:0] fetch_addr;
  logic        fetch_done;
  logic        desc_active;
  logic        rx_ready;
  logic        frame_done;
  logic        wb_done;
  logic        tx_abort;
  logic        rx_abort;
  logic        fc_overflow;
  logic        addr_error;
  logic        mac_status_pend;
  modport device (output fetch_req, fetch_addr, rx_ready,
                  input fetch_done, desc_active, frame_done, wb_done,
                  tx_abort, rx_abort, fc_overflow, addr_error,
                  mac_status_pend);
  modport partner (input fetch_req, fetch_addr, rx_ready,
                   output fetch_done, desc_active, frame_done, wb_done,
                   tx_abort, rx_abort, fc_overflow, addr_error,
                   mac_status_pend);
endinterface

// ==== rtl/edma_status.sv ====
`timescale 1ns/1ps
`include "edma_defines.svh"
module edma_status import edma_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] set_vec,
  input  wire logic        eci_in,
  input  wire logic        clr_we,
  input  wire logic [31:0] clr_data,
  input  wire logic [31:0] permit,
  output logic      [31:0] status,
  output logic             irq
);
  logic [31:0] flags_r;
  logic        irq_r;
  // set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 32'h00000000;
    end else begin
      flags_r <= ((flags_r & ~(clr_we ? clr_data & `STATUS_W1C
                               : 32'h00000000)) | set_vec)
                 & `STATUS_W1C;
    end
  end
  always_comb begin
    status = flags_r;
    status[`BIT_ECI] = eci_in;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_r <= 1'b0;
    else irq_r <= |(status & permit & `STATUS_MASK);
  end
  assign irq = irq_r;
endmodule // edma_status

// ==== rtl/edma_device.sv ====
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "edma_defines.svh"
module edma_device import edma_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             dma_mac_interrupt_request,
  edma_link_if.device      link
);
  logic [31:0] rx_descriptor_list_base_r;
  logic [31:0] permit_r;
  logic [31:0] desc_ptr_r;
  logic [1:0]  dl_r;
  logic        tis_r;
  logic        rr_r;
  logic        halted_r;
  logic        fetch_req_r;
  logic        rx_ready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [31:0] status;
  logic [31:0] set_vec;
  logic        irq;
  logic        wr;
  logic        rd;
  logic        map_hit;
  logic        rr_start;
  logic        rr_stop;
  logic        swr_hit;
  logic        reload_r;
  logic        pready_r;
  rx_state_e   st_r;

  function automatic logic [31:0] desc_step(input logic [1:0] dl);
    case (dl)
      2'h0:    desc_step = 32'h00000010;
      2'h1:    desc_step = 32'h00000020;
      default: desc_step = 32'h00000040;
    endcase
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign map_hit = (paddr == `OFS_MODE) || (paddr == `OFS_RX_REQ) ||
                   (paddr == `OFS_RX_BASE) || (paddr == `OFS_STATUS) ||
                   (paddr == `OFS_PERMIT) || (paddr == `OFS_TX_IRQ_MODE) ||
                   (paddr == `OFS_DESC_PTR);
  // request and reset strobes, decoded once for the receive walker
  assign rr_start = wr && paddr == `OFS_RX_REQ && pwdata[`BIT_RR];
  assign rr_stop  = wr && paddr == `OFS_RX_REQ && !pwdata[`BIT_RR];
  assign swr_hit  = wr && paddr == `OFS_MODE && pwdata[`BIT_SWR];

  always_comb begin
    set_vec = 32'h00000000;
    set_vec[`BIT_WB]    = link.wb_done && tis_r;
    set_vec[`BIT_TRANSMIT_ABORT_FLAG]  = link.tx_abort;
    set_vec[`BIT_RECEIVE_ABORT_FLAG]  = link.rx_abort;
    set_vec[`BIT_FRAME_COUNTER_OVERFLOW_FLAG] = link.fc_overflow;
    set_vec[`BIT_ADE]   = link.addr_error;
  end

  edma_status u_status (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_vec  (set_vec),
    .eci_in   (link.mac_status_pend),
    .clr_we   (wr && paddr == `OFS_STATUS),
    .clr_data (pwdata),
    .permit   (permit_r),
    .status   (status),
    .irq      (irq)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_descriptor_list_base_r <= `RX_BASE_RESET;
      permit_r <= 32'h00000000;
      dl_r     <= 2'h0;
      tis_r    <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `OFS_RX_BASE: rx_descriptor_list_base_r <= pwdata;
        `OFS_PERMIT:  permit_r <= pwdata & `STATUS_MASK;
        `OFS_MODE:    dl_r <= pwdata[`BIT_DL_LO +: 2];
        `OFS_TX_IRQ_MODE: tis_r <= pwdata[`BIT_TIS];
        default: ;
      endcase
    end
  end

  // a software reset returns the receive side to idle and clears halt
  // base is copied only at a software reset and at the first start after a reset, so a rewrite mid-list is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= RX_OFF;
      rr_r        <= 1'b0;
      halted_r    <= 1'b0;
      fetch_req_r <= 1'b0;
      rx_ready_r  <= 1'b0;
      desc_ptr_r  <= 32'h00000000;
      reload_r    <= 1'b1;
    end else if (swr_hit) begin
      st_r        <= RX_OFF;
      rr_r        <= 1'b0;
      halted_r    <= 1'b0;
      fetch_req_r <= 1'b0;
      rx_ready_r  <= 1'b0;
      desc_ptr_r  <= rx_descriptor_list_base_r;
      reload_r    <= 1'b1;
    end else if (link.addr_error || halted_r) begin
      halted_r    <= 1'b1;
      st_r        <= RX_OFF;
      rr_r        <= 1'b0;
      fetch_req_r <= 1'b0;
      rx_ready_r  <= 1'b0;
    end else begin
      case (st_r)
        RX_OFF: begin
          if (rr_start) begin
            rr_r        <= 1'b1;
            fetch_req_r <= 1'b1;
            st_r        <= RX_FETCH;
            // first start after a reset walks from the list base
            if (reload_r) begin
              desc_ptr_r <= rx_descriptor_list_base_r;
              reload_r   <= 1'b0;
            end
          end
        end
        RX_FETCH: begin
          fetch_req_r <= 1'b0;
          st_r        <= RX_WAIT;
        end
        RX_WAIT: begin
          if (link.fetch_done) begin
            if (link.desc_active) begin
              rx_ready_r <= 1'b1;
              st_r       <= RX_READY;
            end else begin
              rr_r <= 1'b0;
              st_r <= RX_OFF;
            end
          end
        end
        RX_READY: begin
          if (rr_stop) begin
            rr_r       <= 1'b0;
            rx_ready_r <= 1'b0;
            st_r       <= RX_OFF;
          end else if (link.frame_done) begin
            rx_ready_r  <= 1'b0;
            desc_ptr_r  <= desc_ptr_r + desc_step(dl_r);
            fetch_req_r <= 1'b1;
            st_r        <= RX_FETCH;
          end
        end
        default: st_r <= RX_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= !map_hit;
      prdata_r  <= 32'h00000000;
      if (rd) begin
        case (paddr)
          `OFS_MODE:    prdata_r <= {26'h0, dl_r, 4'h0};
          `OFS_RX_REQ:  prdata_r <= {31'h0, rr_r};
          `OFS_RX_BASE: prdata_r <= rx_descriptor_list_base_r;
          `OFS_STATUS:  prdata_r <= status & `STATUS_MASK;
          `OFS_PERMIT:  prdata_r <= permit_r;
          `OFS_TX_IRQ_MODE: prdata_r <= {31'h0, tis_r};
          `OFS_DESC_PTR: prdata_r <= desc_ptr_r;
          default: prdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // zero wait states; low in reset and until the first clock edge after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pready_r <= 1'b0;
    else pready_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dma_mac_interrupt_request <= 1'b0;
    else dma_mac_interrupt_request <= irq;
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = pready_r;
  assign link.fetch_req  = fetch_req_r;
  assign link.fetch_addr = desc_ptr_r;
  assign link.rx_ready   = rx_ready_r;
endmodule // edma_device

// ==== rtl/edma_partner.sv ====
`timescale 1ns/1ps
module edma_partner import edma_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ev_fetch_done,
  input  wire logic        ev_desc_active,
  input  wire logic        ev_frame_done,
  input  wire logic        ev_wb_done,
  input  wire logic        ev_tx_abort,
  input  wire logic        ev_rx_abort,
  input  wire logic        ev_fc_overflow,
  input  wire logic        ev_addr_error,
  input  wire logic        ev_mac_pend,
  output logic             seen_fetch,
  output logic      [31:0] seen_addr,
  output logic             seen_ready,
  edma_link_if.partner     link
);
  logic [8:0] ev_r;
  // registered so every link output comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_r       <= 9'h000;
      seen_fetch <= 1'b0;
      seen_addr  <= 32'h00000000;
      seen_ready <= 1'b0;
    end else begin
      ev_r <= {ev_fetch_done, ev_desc_active, ev_frame_done, ev_wb_done,
               ev_tx_abort, ev_rx_abort, ev_fc_overflow, ev_addr_error,
               ev_mac_pend};
      seen_fetch <= link.fetch_req;
      seen_ready <= link.rx_ready;
      if (link.fetch_req) seen_addr <= link.fetch_addr;
    end
  end
  assign link.fetch_done      = ev_r[8];
  assign link.desc_active     = ev_r[7];
  assign link.frame_done      = ev_r[6];
  assign link.wb_done         = ev_r[5];
  assign link.tx_abort        = ev_r[4];
  assign link.rx_abort        = ev_r[3];
  assign link.fc_overflow     = ev_r[2];
  assign link.addr_error      = ev_r[1];
  assign link.mac_status_pend = ev_r[0];
endmodule // edma_partner

// ==== verif/edma_link_props.sv ====
`timescale 1ns/1ps
module edma_link_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic        fetch_done,
  input wire logic        desc_active,
  input wire logic        rx_ready,
  input wire logic        frame_done,
  input wire logic        addr_error
);
  logic [31:0] last_addr_r;
  logic        after_frame_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // remembers the previous fetch so the step after a frame can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr_r <= 32'h0;
      after_frame_r <= 1'b0;
    end else begin
      if (fetch_req) last_addr_r <= fetch_addr;
      if (fetch_req) after_frame_r <= 1'b0;
      else if (rx_ready && frame_done) after_frame_r <= 1'b1;
    end
  end
  sequence fetch_ok;
    fetch_done && desc_active && !addr_error;
  endsequence
  sequence halted;
    (!rx_ready && !fetch_req)[*3];
  endsequence
  a_fetch_single_pulse: assert property (fetch_req |=> !fetch_req)
    else $error("fetch request longer than one cycle");
  a_ready_after_fetch: assert property (fetch_ok |=> rx_ready)
    else $error("no ready after active descriptor");
  a_inactive_no_ready: assert property (
    fetch_done && !desc_active |=> !rx_ready)
    else $error("ready after inactive descriptor");
  a_ready_has_cause: assert property (
    $rose(rx_ready) |-> $past(fetch_done) && $past(desc_active))
    else $error("ready rose without descriptor fetch");
  a_frame_refetch: assert property (
    rx_ready && frame_done && !addr_error |-> ##[1:3] fetch_req)
    else $error("no refetch after frame");
  a_step_boundary: assert property (
    fetch_req && after_frame_r |->
      (fetch_addr - last_addr_r) inside {32'h10, 32'h20, 32'h40})
    else $error("descriptor step not a descriptor length");
  a_pointer_stable: assert property (
    rx_ready && !frame_done |=> $stable(fetch_addr))
    else $error("pointer moved while ready");
  a_halt_on_error: assert property (addr_error |-> ##2 halted)
    else $error("dma still running after address error");
endmodule // edma_link_props

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        seen_ready, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seen_addr, rd;
  logic [8:0]  ev;
  int          miscompares, comparisons, cycles;
  typedef struct {int idx; logic [31:0] exp;} row_s;
  row_s rows [4] = '{'{3, 32'h40000000}, '{4, 32'h04000000},
                     '{5, 32'h02000000}, '{6, 32'h01000000}};
  edma_link_if link ();
  edma_device edma_device_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_mac_interrupt_request(irq), .link(link));
  edma_partner edma_partner_i (.pclk(pclk), .presetn(presetn),
    .ev_fetch_done(ev[0]), .ev_desc_active(ev[1]), .ev_frame_done(ev[2]),
    .ev_wb_done(ev[3]), .ev_tx_abort(ev[4]), .ev_rx_abort(ev[5]),
    .ev_fc_overflow(ev[6]), .ev_addr_error(ev[7]), .ev_mac_pend(ev[8]),
    .seen_fetch(), .seen_addr(seen_addr), .seen_ready(seen_ready),
    .link(link));
  edma_link_props edma_link_props_i (.pclk(pclk), .presetn(presetn),
    .fetch_req(link.fetch_req), .fetch_addr(link.fetch_addr),
    .fetch_done(link.fetch_done), .desc_active(link.desc_active),
    .rx_ready(link.rx_ready), .frame_done(link.frame_done),
    .addr_error(link.addr_error));
  always #10 pclk = ~pclk;
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h008, 32'h0);
    rdchk(12'h00C, 32'h0);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h010, 32'h47C00000);
    foreach (rows[k]) begin
      pulse(rows[k].idx);
      rdchk(12'h00C, rows[k].exp);
      chk(32'(irq), 32'h1);
      apb(1'b1, 12'h00C, 32'h0);
      rdchk(12'h00C, rows[k].exp);
      apb(1'b1, 12'h00C, 32'h47C00000);
      rdchk(12'h00C, 32'h0);
      chk(32'(irq), 32'h0);
    end
    apb(1'b1, 12'h010, 32'h0);
    pulse(5);
    chk(32'(irq), 32'h0);
    apb(1'b1, 12'h00C, 32'h47C00000);
    apb(1'b1, 12'h014, 32'h0);
    pulse(3);
    rdchk(12'h00C, 32'h0);
    ev[8] <= 1'b1;
    @(posedge pclk);
    pulse(4);
    apb(1'b1, 12'h00C, 32'h47C00000);
    rdchk(12'h00C, 32'h00400000);
    ev[8] <= 1'b0;
    @(posedge pclk);
    pulse(4);
    apb(1'b1, 12'h00C, 32'h04000000);
    rdchk(12'h00C, 32'h0);
    rdchk(12'h0FC, 32'h0);
    chk(32'(last_err), 32'h1);
    apb(1'b1, 12'h008, 32'h00001000);
    rdchk(12'h008, 32'h00001000);
    apb(1'b1, 12'h000, 32'h11);
    apb(1'b1, 12'h004, 32'h1);
    repeat (3) @(posedge pclk);
    chk(seen_addr, 32'h00001000);
    ev[1] <= 1'b1;
    @(posedge pclk);
    pulse(0);
    chk(32'(seen_ready), 32'h1);
    pulse(2);
    chk(seen_addr, 32'h00001020);
    pulse(0);
    pulse(7);
    rdchk(12'h004, 32'h0);
    rdchk(12'h00C, 32'h00800000);
    chk(32'(seen_ready), 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    rdchk(12'h018, 32'h00001000);
    apb(1'b1, 12'h004, 32'h1);
    ev[1] <= 1'b0;
    @(posedge pclk);
    pulse(0);
    rdchk(12'h004, 32'h0);
    // mid-run reset, then a start with no software reset before it
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h008, 32'h0);
    rdchk(12'h00C, 32'h0);
    rdchk(12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h00002000);
    apb(1'b1, 12'h000, 32'h20);
    apb(1'b1, 12'h004, 32'h1);
    repeat (3) @(posedge pclk);
    chk(seen_addr, 32'h00002000);
    ev[1] <= 1'b1;
    @(posedge pclk);
    pulse(0);
    pulse(2);
    chk(seen_addr, 32'h00002040);
    pulse(0);
    apb(1'b1, 12'h004, 32'h0);
    rdchk(12'h004, 32'h0);
    chk(32'(seen_ready), 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    pulse(0);
    pulse(2);
    chk(seen_addr, 32'h00002050);
    complete_run();
  end
endmodule // testbench
